/* rtl/hbp_defines.svh */
// hbp_defines.svh: codes, lane masks and reset values of the host bus port
// assumes: included by the port module by bare name
`ifndef HBP_DEFINES_SVH
`define HBP_DEFINES_SVH

// size line codes {size_code_hi, size_code_lo}
`define HBP_SIZE_LONG   2'h0
`define HBP_SIZE_BYTE   2'h1
`define HBP_SIZE_WORD   2'h2
`define HBP_SIZE_FOURTH 2'h3

// register bit reset values
`define HBP_UPS_RST     1'h0
`define HBP_TT0_RST     1'h0

// synchroniser depth and strap settle count
`define HBP_SYNC_STAGES 2
`define HBP_MODE_SETTLE 2'h3

// lane masks
`define HBP_LANES_NONE  4'h0
`define HBP_LANES_ALL   4'hf
`define HBP_LANES_LO16  4'h3
`define HBP_LANES_HI16  4'hc

`endif

/* rtl/hbp_pkg.sv */
// hbp_pkg: types of the multimode host bus port
// assumes: the defines header sits on the include path
package hbp_pkg;

    // four host bus modes, strapped
    typedef enum logic [1:0] {
        HBP_MODE1 = 2'h0,
        HBP_MODE2 = 2'h1,
        HBP_MODE3 = 2'h2,
        HBP_MODE4 = 2'h3
    } hbp_mode_type;

    // master cycle sequencer, gray along idle-addr-wait-end
    typedef enum logic [1:0] {
        HBP_ST_IDLE = 2'h0,
        HBP_ST_ADDR = 2'h1,
        HBP_ST_WAIT = 2'h3,
        HBP_ST_END  = 2'h2
    } hbp_state_type;

endpackage

/* rtl/hbp_sync.sv */
// hbp_sync: two-flop synchroniser for a group of pin levels
// assumes: every bit is a slow level; pulses narrower than a clock are lost
`timescale 1ns/100ps
module hbp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic             ce,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] rst_val,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // =====================================================================
    // two stages; the first feeds only the second
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q   <= '1;
            sync_out <= '1;
        end else if (ce) begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

/* rtl/hbp_port.sv */
// hbp_port: host bus pin multiplexer and cycle sequencer, four bus modes
// assumes: core logic on sys_clk supplies master requests and slave answers;
// pins come from outside and are synchronised before use.
//
// Overview of operation
// - chip select: ack deasserted mode1, inhibit otherwise
// - active-low interrupt output in every mode
// - user status bit driven only while master
// - mode2 transfer type bit, reset zero, master only
// - size lines encode long, byte, word, fourth
// - two-byte slave cycles need alignment, little endian
// - mode3 high/low enables gate lanes 15-8, 7-0
// - mode4 four lane enables, driven and sampled
// - address bits 0,1 dedicated in mode1/2; mode3 bit0, mode4 both become enables
// - mode3/4 slave releases data on ready input
// - mode1 fault on illegal access; fault+halt retries
// - modes2-4 transfer fault, with acknowledge retries
// - transfer active driven by master, floated as slave
// - all sequencing on the host bus clock
`timescale 1ns/100ps
`include "hbp_defines.svh"
module hbp_port
    import hbp_pkg::*;
(
    // clock, reset, enable
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    // straps and arbitration state
    input  wire logic [1:0] mode_sel,
    input  wire logic       bus_master,
    input  wire logic       little_endian,
    // register bits from the core
    input  wire logic       cfg_wr,
    input  wire logic       cfg_ups,
    input  wire logic       cfg_tt0,
    input  wire logic       irq_req,
    input  wire logic       burst_ack_req,
    input  wire logic       burst_inhibit_req,
    // master request from the core
    input  wire logic       m_start,
    input  wire logic [1:0] m_size,
    input  wire logic [1:0] m_addr,
    input  wire logic [3:0] m_lanes,
    // master answer to the core
    output logic            m_busy,
    output logic            m_done,
    output logic            m_retry,
    output logic            m_fault,
    // slave request to the core and its answer
    output logic            s_req,
    output logic [3:0]      s_lanes,
    output logic            s_addr1,
    input  wire logic       s_done,
    input  wire logic       s_read,
    output logic            s_data_oe,
    // single-direction pins
    input  wire logic       cs_n,
    output logic            irq_n,
    output logic            burst_pin_n,
    // status pin: user_status_out or xfer_type_bit0_n
    output logic            stat_pin_o,
    output logic            stat_pin_oe,
    // lane pins 0..3: address, size or lane enables by mode
    input  wire logic [3:0] lane_pin_i,
    output logic [3:0]      lane_pin_o,
    output logic [3:0]      lane_pin_oe,
    // termination pin: sync_cycle_done_n, xfer_ack_n or ready_in_n
    input  wire logic       ack_pin_i,
    output logic            ack_pin_o,
    output logic            ack_pin_oe,
    // fault pin: fault_ack_n or xfer_fault_ack_n
    input  wire logic       flt_pin_i,
    output logic            flt_pin_o,
    output logic            flt_pin_oe,
    // activity pin: halt input or xfer_active_n
    input  wire logic       act_pin_i,
    output logic            act_pin_o,
    output logic            act_pin_oe
);

    // =====================================================================
    // lane mask of a size code at a byte address
    function automatic logic [3:0] size_lanes(input logic [1:0] sz, input logic [1:0] a);
        logic [3:0] m;
        m = `HBP_LANES_ALL;
        unique case (sz)
            `HBP_SIZE_BYTE: m = 4'h1 << a;
            `HBP_SIZE_WORD: m = a[1] ? `HBP_LANES_HI16 : `HBP_LANES_LO16;
            default:        m = `HBP_LANES_ALL;
        endcase
        return m;
    endfunction

    // pair of lanes forming a two-byte cycle
    function automatic logic is_pair(input logic [3:0] m);
        return (m == `HBP_LANES_LO16) || (m == `HBP_LANES_HI16);
    endfunction

    // =====================================================================
    // pin synchronisers
    logic [9:0] raw_w;
    logic [9:0] syn_w;

    assign raw_w = {mode_sel, act_pin_i, flt_pin_i, ack_pin_i, lane_pin_i, cs_n};

    hbp_sync #(.WIDTH(10)) u_sync (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .async_in (raw_w),
        .rst_val  (10'h3ff),
        .sync_out (syn_w)
    );

    logic       cs_s;
    logic [3:0] lp_n;
    logic       ack_s;
    logic       flt_s;
    logic       halt_s;
    logic [1:0] mode_s;

    assign cs_s   = ~syn_w[0];
    assign lp_n   = syn_w[4:1];
    assign ack_s  = ~syn_w[5];
    assign flt_s  = ~syn_w[6];
    assign halt_s = ~syn_w[7];
    assign mode_s = syn_w[9:8];

    // =====================================================================
    // mode strap, reloaded on each of the three cycles before settled, the last load after the synchroniser has filled
    hbp_mode_type mode_q;
    logic [1:0]   settle_q;
    logic         settled;

    assign settled = (settle_q == `HBP_MODE_SETTLE);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_q <= 2'h0;
            mode_q   <= HBP_MODE1;
        end else if (ce && !settled) begin
            settle_q <= settle_q + 2'h1;
            mode_q   <= hbp_mode_type'(mode_s);
        end
    end

    logic m1;
    logic m2;
    logic m34;

    assign m1  = (mode_q == HBP_MODE1);
    assign m2  = (mode_q == HBP_MODE2);
    assign m34 = (mode_q == HBP_MODE3) || (mode_q == HBP_MODE4);

    // =====================================================================
    // register bits: user status and transfer type zero
    logic ups_q;
    logic tt0_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ups_q <= `HBP_UPS_RST;
            tt0_q <= `HBP_TT0_RST;
        end else if (ce && cfg_wr) begin
            ups_q <= cfg_ups;
            tt0_q <= cfg_tt0;
        end
    end

    // =====================================================================
    // slave access decode
    logic [1:0] sl_size;
    logic [1:0] sl_addr;
    logic [3:0] sl_lanes;
    logic       sl_illegal;

    assign sl_size = {lp_n[3], lp_n[2]};
    assign sl_addr = {lp_n[1], lp_n[0]};

    // mode3 keeps address bit 1; bit 0 is the low enable
    assign sl_lanes = m34 ? ((mode_q == HBP_MODE3) ? {2'h0, ~lp_n[2], ~lp_n[0]}
                                                   : {~lp_n[3], ~lp_n[2], ~lp_n[1], ~lp_n[0]})
                          : size_lanes(sl_size, sl_addr);

    // fourth size code is never a legal slave access; mode2 bursts are master only
    assign sl_illegal = (!m34 && sl_size == `HBP_SIZE_FOURTH) ||
                        (!m34 && sl_size == `HBP_SIZE_WORD &&
                         (sl_addr[0] || !little_endian)) ||
                        (m34 && is_pair(sl_lanes) && !little_endian) ||
                        (m34 && sl_lanes == `HBP_LANES_NONE) ||
                        (mode_q == HBP_MODE4 && !is_pair(sl_lanes) &&
                         sl_lanes != `HBP_LANES_ALL && $countones(sl_lanes) != 1);

    // =====================================================================
    // slave cycle
    logic cs_prev_q;
    logic cs_start;
    logic sl_fault_q;
    logic sl_ack_q;
    logic data_oe_q;
    logic s_req_q;

    assign cs_start = cs_s && !cs_prev_q && settled;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_prev_q  <= 1'b0;
            sl_fault_q <= 1'b0;
            s_req_q    <= 1'b0;
        end else if (ce) begin
            cs_prev_q  <= cs_s;
            s_req_q    <= cs_start && !sl_illegal;
            // fault stands until chip select goes away
            sl_fault_q <= cs_s && (sl_fault_q || (cs_start && sl_illegal));
        end
    end

    // slave termination: modes 1/2 answer on the shared pin for one cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sl_ack_q  <= 1'b0;
            data_oe_q <= 1'b0;
        end else if (ce) begin
            sl_ack_q <= s_done && !m34 && cs_s;
            if (s_done && s_read && cs_s) begin
                data_oe_q <= 1'b1;
            end else if (!cs_s || (m34 && ack_s)) begin
                data_oe_q <= 1'b0;
            end
        end
    end

    // =====================================================================
    // master cycle sequencer
    hbp_state_type st_q;
    hbp_state_type st_d;
    logic          ok_w;
    logic          retry_w;
    logic          err_w;

    // mode1 retries on fault with halt; others on fault with acknowledge
    assign retry_w = flt_s && (m1 ? halt_s : ack_s);
    assign err_w   = flt_s && !retry_w;
    assign ok_w    = ack_s && !flt_s;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            HBP_ST_IDLE: if (m_start && bus_master && settled) st_d = HBP_ST_ADDR;
            HBP_ST_ADDR: st_d = HBP_ST_WAIT;
            HBP_ST_WAIT: begin
                if (retry_w) begin
                    st_d = HBP_ST_ADDR;
                end else if (ok_w || err_w) begin
                    st_d = HBP_ST_END;
                end
            end
            HBP_ST_END:  st_d = HBP_ST_IDLE;
        endcase
    end

    logic       wait_q;
    logic [1:0] sz_q;
    logic [1:0] ad_q;
    logic [3:0] ln_q;

    assign wait_q = (st_q == HBP_ST_WAIT);

    // sys_clk is the host bus clock: every state below follows it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= HBP_ST_IDLE;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sz_q    <= `HBP_SIZE_LONG;
            ad_q    <= 2'h0;
            ln_q    <= `HBP_LANES_NONE;
            m_done  <= 1'b0;
            m_retry <= 1'b0;
            m_fault <= 1'b0;
            m_busy  <= 1'b0;
        end else if (ce) begin
            if (st_q == HBP_ST_IDLE && st_d == HBP_ST_ADDR) begin
                sz_q <= m_size;
                ad_q <= m_addr;
                ln_q <= m_lanes;
            end
            m_done  <= wait_q && ok_w;
            m_retry <= wait_q && retry_w;
            m_fault <= wait_q && err_w;
            m_busy  <= (st_d != HBP_ST_IDLE);
        end
    end

    // =====================================================================
    // pin values by mode
    logic [3:0] lane_w;
    logic       act_cyc;

    assign act_cyc = (st_d == HBP_ST_ADDR) || (st_d == HBP_ST_WAIT);

    always_comb begin
        unique case (mode_q)
            HBP_MODE3: lane_w = {1'b1, ~ln_q[1], ad_q[1], ~ln_q[0]};
            HBP_MODE4: lane_w = {~ln_q[3], ~ln_q[2], ~ln_q[1], ~ln_q[0]};
            default:   lane_w = {sz_q[1], sz_q[0], ad_q[1], ad_q[0]};
        endcase
    end

    // =====================================================================
    // registered pin drivers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_n       <= 1'b1;
            burst_pin_n <= 1'b1;
            stat_pin_o  <= 1'b1;
            stat_pin_oe <= 1'b0;
            lane_pin_o  <= 4'hf;
            lane_pin_oe <= 4'h0;
            act_pin_o   <= 1'b1;
            act_pin_oe  <= 1'b0;
        end else if (ce) begin
            irq_n <= ~irq_req;
            // mode1 line ack released on select, other modes burst inhibited
            if (m1) begin
                burst_pin_n <= cs_s ? 1'b1 : ~burst_ack_req;
            end else begin
                burst_pin_n <= cs_s ? 1'b0 : ~burst_inhibit_req;
            end
            stat_pin_o  <= m2 ? ~tt0_q : ups_q;
            stat_pin_oe <= bus_master;
            lane_pin_o  <= lane_w;
            // mode3 has no use for lane pin 3; keep it off
            lane_pin_oe <= {bus_master && (mode_q != HBP_MODE3), {3{bus_master}}};
            act_pin_o   <= ~act_cyc;
            act_pin_oe  <= bus_master && !m1;
        end
    end

    // slave-side answers on the shared pins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_pin_o  <= 1'b1;
            ack_pin_oe <= 1'b0;
            flt_pin_o  <= 1'b1;
            flt_pin_oe <= 1'b0;
            s_lanes    <= `HBP_LANES_NONE;
            s_addr1    <= 1'b0;
            s_req      <= 1'b0;
            s_data_oe  <= 1'b0;
        end else if (ce) begin
            ack_pin_o  <= ~sl_ack_q;
            ack_pin_oe <= sl_ack_q && !bus_master;
            flt_pin_o  <= ~sl_fault_q;
            flt_pin_oe <= sl_fault_q && !bus_master;
            s_req      <= s_req_q;
            if (cs_start) begin
                s_lanes <= sl_lanes;
                s_addr1 <= lp_n[1];
            end
            s_data_oe  <= data_oe_q;
        end
    end

endmodule

/* bench/hbp_port_chk.sv */
// hbp_port_chk: concurrent checks on the pins and core side of hbp_port
// assumes: mode_sel only moves while arst_n is low; bound into every hbp_port
`timescale 1ns/100ps
module hbp_port_chk (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       arst_n,
    // core side
    input wire logic [1:0] mode_sel,
    input wire logic       bus_master,
    input wire logic       irq_req,
    input wire logic       m_busy,
    input wire logic       m_done,
    input wire logic       m_retry,
    input wire logic       s_req,
    // pins
    input wire logic       cs_n,
    input wire logic       irq_n,
    input wire logic       burst_pin_n,
    input wire logic       stat_pin_oe,
    input wire logic [3:0] lane_pin_i,
    input wire logic       ack_pin_i,
    input wire logic       flt_pin_i,
    input wire logic       flt_pin_o,
    input wire logic       flt_pin_oe,
    input wire logic       act_pin_i,
    input wire logic       act_pin_o,
    input wire logic       act_pin_oe
);
    // ======
    // one domain, so clock and disable are given once
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    AST_IRQ_FOLLOWS: assert property (irq_req |=> !irq_n)
        else $error("irq_n not asserted");
    AST_BURST_ON_CS: assert property (
        !cs_n [*5] |-> burst_pin_n == (mode_sel == 2'h0))
        else $error("burst pin wrong while selected");
    AST_STAT_FLOAT: assert property (!bus_master |=> !stat_pin_oe)
        else $error("status pin driven as slave");
    AST_ACT_FLOAT: assert property (!bus_master |=> !act_pin_oe)
        else $error("activity pin driven as slave");
    AST_ACT_START: assert property (
        $rose(m_busy) && mode_sel != 2'h0 |-> act_pin_oe && !act_pin_o)
        else $error("activity pin not driven at cycle start");
    AST_BAD_SIZE: assert property (
        !cs_n [*6] ##0 (mode_sel == 2'h0 && lane_pin_i[3:2] == 2'h3)
        |-> flt_pin_oe && !flt_pin_o)
        else $error("no fault on fourth size code");
    AST_SREQ_CAUSE: assert property (s_req |-> $past(cs_n, 3) == 1'b0
        && !(mode_sel == 2'h0 && lane_pin_i[3:2] == 2'h3))
        else $error("slave request without legal select");
    AST_DONE_ON_ACK: assert property (
        $fell(ack_pin_i) && m_busy && flt_pin_i |-> ##[1:5] m_done)
        else $error("no done after termination");
    AST_RETRY: assert property (
        $fell(flt_pin_i) && m_busy && (mode_sel == 2'h0 ? !act_pin_i : !ack_pin_i)
        |-> ##[1:5] m_retry)
        else $error("no retry after fault");
endmodule

bind hbp_port hbp_port_chk u_chk (.sys_clk, .arst_n, .mode_sel, .bus_master, .irq_req,
    .m_busy, .m_done, .m_retry, .s_req, .cs_n, .irq_n, .burst_pin_n, .stat_pin_oe,
    .lane_pin_i, .ack_pin_i, .flt_pin_i, .flt_pin_o, .flt_pin_oe, .act_pin_i, .act_pin_o,
    .act_pin_oe);

/* bench/hbp_host_model.sv */
// hbp_host_model: host cpu and bus glue facing the port pins
// assumes: bench resolves each pin from the port enable; control lines pull up
`timescale 1ns/100ps
module hbp_host_model (
    // clock
    input  wire logic  sys_clk,
    // host pin levels
    output logic       cs_n,
    output logic [3:0] lane_drv,
    output logic       ack_drv,
    output logic       flt_drv,
    output logic       act_drv
);
    initial begin
        cs_n = 1'b1;
        lane_drv = 4'h5;
        ack_drv = 1'b1;
        flt_drv = 1'b1;
        act_drv = 1'b1;
    end
    // code stays on the lanes for the whole access
    task automatic sel(input logic [3:0] code);
        @(posedge sys_clk);
        #1;
        lane_drv = code;
        cs_n = 1'b0;
    endtask
    // released lanes must not keep the last value
    task automatic desel();
        @(posedge sys_clk);
        #1;
        cs_n = 1'b1;
        lane_drv = ~lane_drv;
    endtask
    // one-cycle termination; a fault pairs with halt in mode 1, else with ack
    task automatic answer(input int dly, input logic flt, input logic m1);
        repeat (dly + 1) @(posedge sys_clk);
        #1;
        ack_drv = flt && m1;
        flt_drv = !flt;
        act_drv = !(flt && m1);
        @(posedge sys_clk);
        #1;
        ack_drv = 1'b1;
        flt_drv = 1'b1;
        act_drv = 1'b1;
    endtask
endmodule

/* bench/hbp_port_test.sv */
// hbp_port_test: self-checking bench for hbp_port in all four modes
// assumes: host model on the pins, the bench plays the core
`timescale 1ns/100ps
module hbp_port_test
    import hbp_pkg::*;
;
    typedef struct packed {
        hbp_mode_type mode;
        logic         le;
        logic [3:0]   sl;
        logic         ok;
        logic         flt;
        logic [3:0]   lo;
        logic [3:0]   lm;
        logic         st;
    } hbp_row_type;
    // mode, endian, slave lanes, legal, master fault, lane pins, mask, status
    hbp_row_type rows [8] = '{
        '{HBP_MODE1, 1'b0, 4'h0, 1'b1, 1'b1, 4'h4, 4'hf, 1'b1},
        '{HBP_MODE1, 1'b0, 4'hc, 1'b0, 1'b0, 4'h4, 4'hf, 1'b1},
        '{HBP_MODE2, 1'b1, 4'h8, 1'b1, 1'b1, 4'h4, 4'hf, 1'b0},
        '{HBP_MODE2, 1'b0, 4'h8, 1'b0, 1'b0, 4'h4, 4'hf, 1'b0},
        '{HBP_MODE3, 1'b1, 4'h8, 1'b1, 1'b0, 4'h4, 4'h7, 1'b1},
        '{HBP_MODE3, 1'b0, 4'h8, 1'b0, 1'b1, 4'h4, 4'h7, 1'b1},
        '{HBP_MODE4, 1'b1, 4'h0, 1'b1, 1'b1, 4'he, 4'hf, 1'b1},
        '{HBP_MODE4, 1'b1, 4'hf, 1'b0, 1'b0, 4'he, 4'hf, 1'b1}};
    hbp_row_type r;
    logic       sys_clk = 1'b0;
    logic       arst_n, ce, bus_master, little_endian, cfg_wr, cfg_ups, cfg_tt0, irq_req;
    logic       burst_ack_req, burst_inhibit_req, m_start, s_done, s_read;
    logic [1:0] mode_sel, m_size, m_addr;
    logic [3:0] m_lanes, s_lanes, lane_pin_i, lane_pin_o, lane_pin_oe, lane_drv;
    logic       m_busy, m_done, m_retry, m_fault, s_req, s_addr1, s_data_oe, cs_n, irq_n;
    logic       burst_pin_n, stat_pin_o, stat_pin_oe, ack_pin_i, ack_pin_o, ack_pin_oe;
    logic       flt_pin_i, flt_pin_o, flt_pin_oe, act_pin_i, act_pin_o, act_pin_oe;
    logic       ack_drv, flt_drv, act_drv;
    int         err_total = 0;
    int         compares = 0;

    always #5 sys_clk = ~sys_clk;
    // shared wires: whoever enables drives, else the host level
    assign lane_pin_i = (lane_pin_oe & lane_pin_o) | (~lane_pin_oe & lane_drv);
    assign ack_pin_i = ack_pin_oe ? ack_pin_o : ack_drv;
    assign flt_pin_i = flt_pin_oe ? flt_pin_o : flt_drv;
    assign act_pin_i = act_pin_oe ? act_pin_o : act_drv;

    hbp_port uut (.sys_clk, .arst_n, .ce, .mode_sel, .bus_master, .little_endian, .cfg_wr,
        .cfg_ups, .cfg_tt0, .irq_req, .burst_ack_req, .burst_inhibit_req, .m_start, .m_size,
        .m_addr, .m_lanes, .m_busy, .m_done, .m_retry, .m_fault, .s_req, .s_lanes, .s_addr1,
        .s_done, .s_read, .s_data_oe, .cs_n, .irq_n, .burst_pin_n, .stat_pin_o, .stat_pin_oe,
        .lane_pin_i, .lane_pin_o, .lane_pin_oe, .ack_pin_i, .ack_pin_o, .ack_pin_oe,
        .flt_pin_i, .flt_pin_o, .flt_pin_oe, .act_pin_i, .act_pin_o, .act_pin_oe);
    hbp_host_model host (.sys_clk, .cs_n, .lane_drv, .ack_drv, .flt_drv, .act_drv);

    // ======
    // shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic seen_ev(input int k);
        case (k)
            0: return m_busy === 1'b1;
            1: return (m_done | m_retry | m_fault) === 1'b1;
            2: return (s_req | flt_pin_oe) === 1'b1;
            3: return s_data_oe === 1'b1;
            default: return s_data_oe === 1'b0;
        endcase
    endfunction
    task automatic await(input int k, input int lim);
        int n;
        n = 0;
        while (!seen_ev(k)) begin
            if (n == lim) begin
                err_total++;
                $display("[FAIL] event %0d expected 1 seen 0", k);
                test_done();
            end
            tick(1);
            n++;
        end
    endtask
    task automatic do_reset(input hbp_mode_type m);
        arst_n = 1'b0;
        bus_master = 1'b0;
        mode_sel = m;
        tick(8);
        check("reset", {irq_n, burst_pin_n, m_busy, stat_pin_oe, ack_pin_oe, flt_pin_oe,
            act_pin_oe, |lane_pin_oe}, 8'hc0);
        arst_n = 1'b1;
        tick(6);
    endtask
    task automatic mstart();
        bus_master = 1'b1;
        tick(2);
        m_start = 1'b1;
        tick(1);
        m_start = 1'b0;
        await(0, 4);
    endtask

    initial begin
        {arst_n, ce, bus_master, little_endian, cfg_wr, irq_req} = 6'h10;
        {burst_ack_req, burst_inhibit_req, m_start, s_done, s_read} = 5'h10;
        {cfg_ups, cfg_tt0, mode_sel, m_size, m_addr, m_lanes} = 12'hc41;
        foreach (rows[i]) begin
            r = rows[i];
            do_reset(r.mode);
            little_endian = r.le;
            irq_req = 1'b1;
            tick(2);
            check("irq_n", irq_n, 1'b0);
            irq_req = 1'b0;
            cfg_wr = 1'b1;
            tick(1);
            cfg_wr = 1'b0;
            host.sel(r.sl);
            await(2, 8);
            check("s_req", s_req, r.ok);
            // modes 2 and 3 rows select a low word, modes 1 and 4 a long word
            if (r.ok) check("lanes", {s_addr1, s_lanes}, ^r.mode ? 5'h03 : 5'h0f);
            check("fault pin", flt_pin_oe & ~flt_pin_o, !r.ok);
            tick(1);
            check("burst_pin_n", burst_pin_n, r.mode == HBP_MODE1);
            if (r.ok) begin
                s_read = 1'b1;
                s_done = 1'b1;
                tick(1);
                s_done = 1'b0;
                await(3, 6);
                check("slave ack", ack_pin_oe & ~ack_pin_o, r.mode < HBP_MODE3);
                tick(3);
                check("data held", s_data_oe, 1'b1);
                if (r.mode > HBP_MODE2) host.answer(0, 1'b0, 1'b0);
                else host.desel();
                await(4, 6);
            end
            host.desel();
            mstart();
            // lane pins follow the captured request one edge after the start
            tick(1);
            check("lane pins", lane_pin_o & r.lm, r.lo);
            check("status pin", {stat_pin_oe, stat_pin_o}, {1'b1, r.st});
            check("act pin", act_pin_oe & ~act_pin_o, r.mode != HBP_MODE1);
            fork
                host.answer(2, r.flt, r.mode == HBP_MODE1);
                await(1, 12);
            join
            check("retry", m_retry, r.flt);
            if (r.flt) begin
                tick(1);
                fork
                    host.answer(0, 1'b0, 1'b0);
                    await(1, 12);
                join
            end
            check("done", m_done, 1'b1);
            tick(2);
            bus_master = 1'b0;
            tick(2);
            check("float", {stat_pin_oe, act_pin_oe, |lane_pin_oe}, 3'h0);
            $display("row %0d done", i);
        end
        // transfer type bit must come out of reset deasserted
        do_reset(HBP_MODE2);
        bus_master = 1'b1;
        tick(3);
        check("tt0 default", {stat_pin_oe, stat_pin_o}, 2'h3);
        $display("tt0 default done");
        // slow slave: the cycle stays open until ready comes
        do_reset(HBP_MODE3);
        mstart();
        tick(20);
        check("busy waiting", m_busy, 1'b1);
        fork
            host.answer(0, 1'b0, 1'b0);
            await(1, 12);
        join
        check("slow done", m_done, 1'b1);
        $display("slow slave done");
        // fault with ready left high: the cycle ends in error, no retry
        tick(2);
        mstart();
        fork
            host.answer(0, 1'b1, 1'b1);
            await(1, 12);
        join
        check("fault end", {m_fault, m_retry, m_done}, 3'h4);
        $display("fault end done");
        test_done();
    end
endmodule
